// ---- hdl/ssps_pkg.sv ----
// shared constants for the synchronous sram port state block
package ssps_pkg;
  // power-up settle time in microseconds and the core clock rate
  localparam int unsigned POWER_UP_SETTLE_US = 1000;
  localparam int unsigned CORE_CLK_MHZ = 50;
  localparam int unsigned POWER_UP_SETTLE_CYCLES =
    POWER_UP_SETTLE_US * CORE_CLK_MHZ;
  // default geometry
  localparam int unsigned LANES_DEFAULT = 4;
  localparam int unsigned ADDR_W_DEFAULT = 4;
  // reset value of the output enable
  localparam logic DQ_OE_RESET = 1'h0;
endpackage

// ---- hdl/ssps_port.sv ----
// sram host port: select decode, writes, bus tri-state, sleep
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Function
// - selected only when primary select low, second high, third low.
// - full write by all-bytes write low, or gate and every lane select low.
// - after a write the data bus stays tri-stated until a new read starts.
// - on leaving sleep the data lines stay tri-stated until a read starts.
module ssps_port
  import ssps_pkg::*;
#(
  parameter int unsigned LANES = LANES_DEFAULT,
  parameter int unsigned ADDR_W = ADDR_W_DEFAULT,
  parameter int unsigned SETTLE_CYCLES = POWER_UP_SETTLE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PRIMARY_SELECT_N,
  input wire logic SECOND_SELECT,
  input wire logic THIRD_SELECT_N,
  input wire logic PROCESSOR_ADDR_STROBE_N,
  input wire logic CONTROLLER_ADDR_STROBE_N,
  input wire logic ALL_BYTES_WRITE_N,
  input wire logic LANE_WRITE_GATE_N,
  input wire logic [LANES-1:0] LANE_WRITE_SELECT_N,
  input wire logic SLEEP_REQUEST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [8*LANES-1:0] DQ_IN,
  output logic [8*LANES-1:0] DQ_OUT,
  output logic DQ_OE,
  output logic SETTLED
);
  // refuse geometries that the array and the counter cannot serve
  if (LANES < 1 || ADDR_W < 1 || ADDR_W > 12 ||
      SETTLE_CYCLES < 1) begin : g_bad_params
    $error("ssps_port: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////
  // decode of select, strobes and write enables
  wire logic selected;
  wire logic sleeping;
  wire logic any_strobe;
  wire logic read_start;
  wire logic write_any;
  wire logic [LANES-1:0] lane_we;
  wire logic write_full;

  assign selected = !PRIMARY_SELECT_N && SECOND_SELECT && !THIRD_SELECT_N;
  assign sleeping = SLEEP_REQUEST;
  assign any_strobe = !PROCESSOR_ADDR_STROBE_N || !CONTROLLER_ADDR_STROBE_N;
  // a strobe with the device selected, not sleeping and no write begins a read
  assign read_start = any_strobe && selected && !sleeping && !write_any;
  // per-lane enables: global write covers all lanes
  assign lane_we = !ALL_BYTES_WRITE_N ? {LANES{1'b1}} :
                   (!LANE_WRITE_GATE_N ? ~LANE_WRITE_SELECT_N :
                    {LANES{1'b0}});
  assign write_full = &lane_we;
  assign write_any = |lane_we && selected && !sleeping;

  ////////////////////////////////////////////////////////////////////////
  // storage array, one generate branch per byte lane
  localparam int unsigned DEPTH = 1 << ADDR_W;
  wire logic [8*LANES-1:0] rd_word;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      // each lane owns its bytes, so every array has a single writer
      logic [7:0] lane_mem [0:DEPTH-1];
      always_ff @(posedge CORE_CLK) begin
        if (write_any && lane_we[g]) begin
          lane_mem[ADDR] <= DQ_IN[8*g +: 8];
        end
      end
      // lane g feeds bits 8g+7:8g of the read word
      assign rd_word[8*g +: 8] = lane_mem[ADDR];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // power-up settle counter, drives SETTLED only; reads and writes are not gated by it
  localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 1);
  logic [CNT_W-1:0] settle_cnt;
  wire logic settle_done;
  assign settle_done = settle_cnt == CNT_W'(SETTLE_CYCLES);

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      settle_cnt <= '0;
      SETTLED <= 1'h0;
    end else begin
      if (!settle_done) begin
        settle_cnt <= settle_cnt + CNT_W'(1);
      end
      SETTLED <= settle_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output enable and read data
  wire logic next_dq_oe;
  // reads open the bus; writes, deselect strobes and sleep close it
  assign next_dq_oe = sleeping ? 1'b0 :
                      (read_start ? 1'b1 :
                       ((write_any || (any_strobe && !selected)) ? 1'b0 :
                        DQ_OE));

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      DQ_OE <= DQ_OE_RESET;
      DQ_OUT <= '0;
    end else begin
      DQ_OE <= next_dq_oe;
      if (read_start) begin
        DQ_OUT <= rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_write;
    write_any;
  endsequence
  sequence s_idle_after;
    !read_start && !sleeping;
  endsequence

  property p_write_closes;
    @(posedge CORE_CLK) disable iff (RESET)
      s_write ##1 s_idle_after |=> !DQ_OE;
  endproperty
  a_write_closes: assert property (p_write_closes)
    else $error("bus driven after write without read");

  property p_read_opens;
    @(posedge CORE_CLK) disable iff (RESET)
      read_start |=> DQ_OE;
  endproperty
  a_read_opens: assert property (p_read_opens)
    else $error("read start did not drive bus");

  property p_sleep_exit;
    @(posedge CORE_CLK) disable iff (RESET)
      $fell(SLEEP_REQUEST) && !read_start |=> !DQ_OE;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit)
    else $error("bus driven on sleep exit");

  property p_deselect_nowrite;
    @(posedge CORE_CLK) disable iff (RESET)
      !selected |-> !write_any;
  endproperty
  a_deselect_nowrite: assert property (p_deselect_nowrite)
    else $error("write accepted while deselected");

  property p_select_decode;
    @(posedge CORE_CLK) disable iff (RESET)
      read_start |-> !PRIMARY_SELECT_N && SECOND_SELECT && !THIRD_SELECT_N;
  endproperty
  a_select_decode: assert property (p_select_decode)
    else $error("read started with bad select");

  property p_full_write;
    @(posedge CORE_CLK) disable iff (RESET)
      (ALL_BYTES_WRITE_N && !LANE_WRITE_GATE_N &&
       LANE_WRITE_SELECT_N == '0) |-> write_full;
  endproperty
  a_full_write: assert property (p_full_write)
    else $error("gate plus all lanes not a full write");

  property p_sleep_nowrite;
    @(posedge CORE_CLK) disable iff (RESET)
      SLEEP_REQUEST |-> !write_any && !read_start;
  endproperty
  a_sleep_nowrite: assert property (p_sleep_nowrite)
    else $error("access accepted while sleeping");

  property p_settled_hold;
    @(posedge CORE_CLK) disable iff (RESET)
      SETTLED |=> SETTLED;
  endproperty
  a_settled_hold: assert property (p_settled_hold)
    else $error("settled flag dropped");

  sequence s_deselect_strobe;
    any_strobe && !selected;
  endsequence

  property p_write_closes_now;
    @(posedge CORE_CLK) disable iff (RESET)
      s_write |=> !DQ_OE;
  endproperty
  a_write_closes_now: assert property (p_write_closes_now)
    else $error("bus still driven the cycle after a write");

  property p_deselect_closes;
    @(posedge CORE_CLK) disable iff (RESET)
      s_deselect_strobe |=> !DQ_OE;
  endproperty
  a_deselect_closes: assert property (p_deselect_closes)
    else $error("bus driven after a deselecting strobe");

  property p_sleep_closes;
    @(posedge CORE_CLK) disable iff (RESET)
      SLEEP_REQUEST |=> !DQ_OE;
  endproperty
  a_sleep_closes: assert property (p_sleep_closes)
    else $error("bus driven during sleep");

  property p_bus_holds;
    @(posedge CORE_CLK) disable iff (RESET)
      !any_strobe && !write_any && !sleeping |=> $stable(DQ_OE);
  endproperty
  a_bus_holds: assert property (p_bus_holds)
    else $error("bus enable changed with no access");

  property p_read_data;
    @(posedge CORE_CLK) disable iff (RESET)
      read_start |=> DQ_OUT == $past(rd_word);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not taken from the array");

  property p_settle_count;
    @(posedge CORE_CLK) disable iff (RESET)
      $rose(SETTLED) |-> settle_done;
  endproperty
  a_settle_count: assert property (p_settle_count)
    else $error("settled flag rose before the count ended");
endmodule
`default_nettype wire

// ---- test/ssps_host.sv ----
// controller-side model driving the sram host port
`timescale 1ns/1ps
`default_nettype none
module ssps_host (
  input wire logic clk,
  input wire logic settled,
  output logic [6:0] ctl,
  output logic [3:0] lane_n,
  output logic [3:0] addr,
  output logic [31:0] wdat,
  output logic sleep
);
  // ctl: primary_n, second, third_n, proc/ctrl strobe_n, all_n, gate_n
  localparam logic [6:0] IDLE = 7'h5F;
  // idle and deselected from time zero
  initial begin
    ctl = IDLE;
    lane_n = 4'hF;
    addr = 4'h0;
    wdat = 32'h0;
    sleep = 1'b0;
  end
  // one cycle of request, then back to idle
  task automatic cyc(input logic [6:0] c, input logic [3:0] l,
                     input logic [3:0] a, input logic [31:0] d);
    @(negedge clk);
    {ctl, lane_n, addr, wdat} = {c, l, a, d};
    @(negedge clk);
    {ctl, lane_n} = {IDLE, 4'hF};
  endtask
  // no access before the settle flag
  task automatic wait_settle();
    for (int k = 0; k < 100 && settled !== 1'b1; k++) @(negedge clk);
  endtask
  // deselecting strobe before sleep entry
  task automatic snooze(input logic on);
    if (on) cyc(7'h57, 4'hF, 4'h0, 32'h0);
    @(negedge clk);
    sleep = on;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_ssps_port.sv ----
// self-checking bench for the sram host port
`timescale 1ns/1ps
`default_nettype none
module tb_ssps_port;
  logic clk, rst, oe, settled, sl;
  logic [6:0] c;
  logic [3:0] ln, ad;
  logic [31:0] wd, rdat;
  int n_fail = 0, n_tests = 0, cycles = 0;
  ssps_host host (.clk(clk), .settled(settled), .ctl(c), .lane_n(ln),
    .addr(ad), .wdat(wd), .sleep(sl));
  ssps_port #(.LANES(4), .ADDR_W(4), .SETTLE_CYCLES(8)) DUT (
    .CORE_CLK(clk), .RESET(rst), .PRIMARY_SELECT_N(c[6]),
    .SECOND_SELECT(c[5]), .THIRD_SELECT_N(c[4]),
    .PROCESSOR_ADDR_STROBE_N(c[3]), .CONTROLLER_ADDR_STROBE_N(c[2]),
    .ALL_BYTES_WRITE_N(c[1]), .LANE_WRITE_GATE_N(c[0]),
    .LANE_WRITE_SELECT_N(ln), .SLEEP_REQUEST(sl), .ADDR(ad), .DQ_IN(wd),
    .DQ_OUT(rdat), .DQ_OE(oe), .SETTLED(settled));
  ////////////////////////////////////////////////////////////////////////
  // compare helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [6:0] k, input logic [3:0] a,
                    input logic [31:0] e);
    host.cyc(k, 4'hF, a, 32'h0);
    chk("dq_oe", 32'h1, {31'h0, oe});
    chk("dq_out", e, rdat);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // both full-width write paths, bus closed after each full-width write
  task automatic t_writes();
    host.cyc(7'h2D, 4'hF, 4'h1, 32'hA5A50001);
    chk("dq_oe", 32'h0, {31'h0, oe});
    rd(7'h27, 4'h1, 32'hA5A50001);
    host.cyc(7'h2E, 4'h0, 4'h2, 32'h5A5A0002);
    chk("dq_oe", 32'h0, {31'h0, oe});
    rd(7'h2B, 4'h2, 32'h5A5A0002);
    host.cyc(7'h2E, 4'hA, 4'h2, 32'hFFFFFFFF);
    rd(7'h27, 4'h2, 32'h5AFF00FF);
    host.cyc(7'h2F, 4'h0, 4'h2, 32'h00000000);
    rd(7'h27, 4'h2, 32'h5AFF00FF);
  endtask
  // every select combination but one deselects and blocks writes
  task automatic t_decode();
    host.cyc(7'h2D, 4'hF, 4'h3, 32'h12345678);
    for (int s = 0; s < 8; s++) begin
      if (s != 2) begin
        rd(7'h27, 4'h3, 32'h12345678);
        host.cyc({s[2:0], 4'h5}, 4'hF, 4'h3, 32'hDEAD0000);
        chk("dq_oe", 32'h0, {31'h0, oe});
      end
    end
    rd(7'h27, 4'h3, 32'h12345678);
  endtask
  // sleep ignores writes, bus stays closed after exit until a read
  task automatic t_sleep();
    rd(7'h27, 4'h1, 32'hA5A50001);
    host.snooze(1'b1);
    host.cyc(7'h2D, 4'hF, 4'h1, 32'h0BAD0BAD);
    host.cyc(7'h27, 4'hF, 4'h1, 32'h00000000);
    chk("dq_oe", 32'h0, {31'h0, oe});
    host.snooze(1'b0);
    repeat (3) begin
      @(negedge clk);
      chk("dq_oe", 32'h0, {31'h0, oe});
    end
    rd(7'h27, 4'h1, 32'hA5A50001);
  endtask
  // hold reset, check the cleared outputs, then wait for the settle flag
  task automatic t_reset(input int n);
    rst = 1'b1;
    repeat (n) @(negedge clk);
    rst = 1'b0;
    chk("dq_oe", 32'h0, {31'h0, oe});
    chk("dq_out", 32'h0, rdat);
    chk("settled", 32'h0, {31'h0, settled});
    host.wait_settle();
    chk("settled", 32'h1, {31'h0, settled});
  endtask
  // reset in mid-run with the bus open; the array keeps its contents
  task automatic t_restart();
    rd(7'h27, 4'h1, 32'hA5A50001);
    t_reset(2);
    rd(7'h2B, 4'h1, 32'hA5A50001);
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    t_reset(6);
    t_writes();
    t_decode();
    t_sleep();
    t_restart();
    tally_and_finish();
  end
endmodule
`default_nettype wire
